// >>> inc/psq_pkg.sv
// shared constants, types and register map of the port sequencer
package psq_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned BACKOFF_MS     = 100;
  localparam int unsigned MID_BACKOFF_MS = 2000;
  localparam int unsigned CLASS_MS       = 12;
  localparam int unsigned MARK_US        = 10;
  localparam int unsigned STEP_US        = 20;
  localparam int unsigned BACKOFF_CYC    = BACKOFF_MS * 1000 * CLK_MHZ;
  localparam int unsigned MID_BACKOFF_CYC = MID_BACKOFF_MS * 1000 * CLK_MHZ;
  localparam int unsigned CLASS_CYC      = CLASS_MS * 1000 * CLK_MHZ;
  localparam int unsigned MARK_CYC       = MARK_US * CLK_MHZ;
  localparam int unsigned STEP_CYC       = STEP_US * CLK_MHZ;
  localparam logic [1:0]  STRAP_WAIT     = 2'd2;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] CMD_ADDR    = 12'h004;
  localparam logic [11:0] STATUS_ADDR = 12'h008;
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_DET_EN  = 2;
  localparam int CTRL_CLS_EN  = 3;
  localparam int CTRL_LEG_EN  = 4;
  localparam int CTRL_PP_EN   = 5;
  localparam int CTRL_HP_EN   = 6;
  localparam int CMD_DET      = 0;
  localparam int CMD_CLS      = 1;
  localparam int CMD_PWR_ON   = 2;
  localparam int CMD_PWR_OFF  = 3;
  localparam int ST_CLS_LO    = 4;
  localparam int ST_SECOND    = 8;
  localparam int ST_PWR       = 9;
  localparam int ST_TSTART    = 10;
  localparam int ST_ICUT_LO   = 12;
  localparam int ST_ILIM_LO   = 22;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // ----------------------------------------------------------------
  // operating modes, detection codes, classes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SHUTDOWN = 2'b00;
  localparam logic [1:0] MODE_MANUAL   = 2'b01;
  localparam logic [1:0] MODE_SEMI     = 2'b10;
  localparam logic [1:0] MODE_AUTO     = 2'b11;

  typedef enum logic [2:0] {
    DET_UNKNOWN, DET_SHORT, DET_CPD_HIGH, DET_RSIG_LOW,
    DET_GOOD, DET_RSIG_HIGH, DET_OPEN, DET_VOLT_OUT
  } det_e;

  localparam logic [2:0] CLS_4 = 3'd4;

  // measurement thresholds: mV, and resistance in 100 ohm units
  localparam logic [15:0] SHORT_MV     = 16'h03e8; // 1 V
  localparam logic [15:0] RANGE_MV     = 16'h2710; // 10 V
  localparam logic [15:0] RES_SHORT    = 16'h0018; // 2.4k
  localparam logic [15:0] RES_GOOD_LO  = 16'h00aa; // 17k
  localparam logic [15:0] RES_GOOD_HI  = 16'h0122; // 29k
  localparam logic [15:0] RES_OPEN     = 16'h01f4; // 50k

  // overload cut and current limit in mA
  localparam logic [9:0] ICUT_C1 = 10'h070; // 112
  localparam logic [9:0] ICUT_C2 = 10'h0ce; // 206
  localparam logic [9:0] ICUT_C3 = 10'h177; // 375
  localparam logic [9:0] ICUT_C4 = 10'h27e; // 638
  localparam logic [9:0] ILIM_LO = 10'h1a9; // 425
  localparam logic [9:0] ILIM_HI = 10'h352; // 850

  // front end force selection
  typedef enum logic [2:0] {
    F_OFF, F_CUR1, F_CUR2, F_VOLT1, F_VOLT2, F_CLASS, F_MARK
  } force_e;

  // one measurement returned by the front end
  typedef struct packed {
    logic [15:0] volt_mv;
    logic [15:0] res_hohm;
    logic        cap_high;
    logic        cap_legacy;
    logic [2:0]  cls;
  } meas_s;

endpackage : psq_pkg

// >>> hw/sig_encoder.sv
// signature code encoder and class to threshold lookup
`timescale 1ns/1ps
module sig_encoder
  import psq_pkg::*;
(
  input  wire logic [15:0] res_hohm,
  input  wire logic        cap_high,
  input  wire logic        cap_legacy,
  input  wire logic        legacy_en,
  input  wire logic [2:0]  cls,
  output det_e             code,
  output logic [9:0]       icut_ma,
  output logic [9:0]       ilim_ma
);

  // resistance bands; legacy capacitance wins only when enabled
  always_comb
  begin
    if (legacy_en && cap_legacy)
      code = DET_GOOD;
    else if (cap_high)
      code = DET_CPD_HIGH;
    else if (res_hohm < RES_SHORT)
      code = DET_SHORT;
    else if (res_hohm < RES_GOOD_LO)
      code = DET_RSIG_LOW;
    else if (res_hohm <= RES_GOOD_HI)
      code = DET_GOOD;
    else if (res_hohm > RES_OPEN)
      code = DET_OPEN;
    else
      code = DET_RSIG_HIGH;
  end

  // class 0 is handled like class 3
  always_comb
  begin
    ilim_ma = ILIM_LO;
    unique case (cls)
      3'd1:    icut_ma = ICUT_C1;
      3'd2:    icut_ma = ICUT_C2;
      3'd4:
      begin
        icut_ma = ICUT_C4;
        ilim_ma = ILIM_HI;
      end
      default: icut_ma = ICUT_C3;
    endcase
  end

endmodule : sig_encoder

// >>> hw/port_sequencer.sv
// detection and classification sequencer for one port, apb slave
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - force two currents first; force voltages only after a good result
// - detect good needs both current and voltage results good
// - signature 17k to 29k is reported as detect good
// - under 1V at first current step aborts and reports short
// - distinct codes: unknown, short, low, high, open, capacitance
// - port above 10V reports voltage outside detect range
// - manual mode runs one detection per host command then idles
// - semi-auto polls repeatedly and posts status after every cycle
// - after good detect wait 100ms, or 2s with midspan strap
// - semi-auto high power: power-on only on good, else start fault
// - standalone mode powers on automatically after good and class
// - detection off for reserved mode, shutdown or clear detect enable
// - legacy capacitance detect is off at reset, enabled per port
// - classify right after good detect, or on command in manual
// - class step forces class voltage 12ms then posts class
// - classes 0 to 4; class 0 treated as class 3
// - standalone mode sets cut and limit from class
// - class off for reserved mode, shutdown or clear class enable
// - two-event: class 4 then mark voltage, pause, classify again; code goes from the mark step straight to the second class step
// - second class cycle sets its status indicator bit
// - second cycle only with its enable and a first class 4
// - mode field: 11 standalone, 10 semi-auto, 01 manual, 00 off
// - standalone cut 112/206/375/638mA, limit 425 or 850mA
// - standalone class 4 then lower class: no power, redetect
module port_sequencer
  import psq_pkg::*;
#(
  parameter int unsigned BACKOFF_CYCLES     = BACKOFF_CYC,
  parameter int unsigned MID_BACKOFF_CYCLES = MID_BACKOFF_CYC,
  parameter int unsigned CLASS_CYCLES       = CLASS_CYC
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        auto_strap_pin,
  input  wire logic        mid_strap_pin,
  output force_e           afe_force,
  output logic             afe_sample,
  input  wire logic        afe_done,
  input  wire meas_s       afe_meas,
  output logic             port_power_on,
  output logic [9:0]       icut_ma,
  output logic [9:0]       ilim_ma
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_DI1, S_DI2, S_DV1, S_DV2, S_CLS1, S_MARK, S_CLS2, S_HOLD
  } st_e;

  st_e         state;
  logic [31:0] timer;
  logic        armed;
  logic        auto_pwr;
  logic        cur_good;
  det_e        det_code;
  logic [2:0]  cls_q;
  logic        second_ran;
  logic        tstart_fault;
  logic [6:0]  ctrl;
  logic        auto1, auto2, mid1, mid2;
  logic        auto_strap, mid_strap;
  logic [1:0]  strap_cnt;
  logic        done1, done2, done3;
  meas_s       meas1, meas_q;
  det_e        enc_code;
  logic [9:0]  enc_icut, enc_ilim;
  logic        acc, wr, cmd_wr, meas_ev, strap_now;
  logic [1:0]  mode;
  logic        det_ok, cls_ok, start_det, start_cls;
  logic [31:0] backoff;

  // ----------------------------------------------------------------
  // synchronisers for front end and strap pins
  // ----------------------------------------------------------------
  // meas is held stable by the front end while done is high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done1  <= 1'b0;
      done2  <= 1'b0;
      done3  <= 1'b0;
      meas1  <= '0;
      meas_q <= '0;
      auto1  <= 1'b0;
      auto2  <= 1'b0;
      mid1   <= 1'b0;
      mid2   <= 1'b0;
    end
    else
    begin
      done1  <= afe_done;
      done2  <= done1;
      done3  <= done2;
      meas1  <= afe_meas;
      meas_q <= meas1;
      auto1  <= auto_strap_pin;
      auto2  <= auto1;
      mid1   <= mid_strap_pin;
      mid2   <= mid1;
    end
  end

  // straps are caught once after reset release, never later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_cnt  <= 2'd0;
      auto_strap <= 1'b0;
      mid_strap  <= 1'b0;
    end
    else if (strap_cnt != 2'd3)
    begin
      strap_cnt <= strap_cnt + 2'd1;
      if (strap_now)
      begin
        auto_strap <= auto2;
        mid_strap  <= mid2;
      end
    end
  end

  assign strap_now = (strap_cnt == STRAP_WAIT);
  assign meas_ev   = done2 & ~done3;
  assign mode      = ctrl[CTRL_MODE_LO +: 2];
  assign backoff   = mid_strap ? MID_BACKOFF_CYCLES : BACKOFF_CYCLES;

  // reserved mode 11 without the strap behaves as disabled
  assign det_ok = ctrl[CTRL_DET_EN] && mode != MODE_SHUTDOWN &&
                  (mode != MODE_AUTO || auto_strap);
  assign cls_ok = ctrl[CTRL_CLS_EN] && mode != MODE_SHUTDOWN &&
                  (mode != MODE_AUTO || auto_strap);

  // ----------------------------------------------------------------
  // apb slave: one wait state, errors on unmapped addresses
  // ----------------------------------------------------------------
  assign acc    = psel & penable & pready;
  assign wr     = acc & pwrite;
  assign cmd_wr = wr && paddr == CMD_ADDR;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & paddr != CTRL_ADDR &
                 paddr != CMD_ADDR & paddr != STATUS_ADDR;
      prdata  <= 32'h0000_0000;
      if (psel && !pwrite && paddr == CTRL_ADDR)
        prdata[6:0] <= ctrl;
      else if (psel && !pwrite && paddr == STATUS_ADDR)
      begin
        prdata[2:0]                <= det_code;
        prdata[ST_CLS_LO +: 3]     <= cls_q;
        prdata[ST_SECOND]          <= second_ran;
        prdata[ST_PWR]             <= port_power_on;
        prdata[ST_TSTART]          <= tstart_fault;
        prdata[ST_ICUT_LO +: 10]   <= icut_ma;
        prdata[ST_ILIM_LO +: 10]   <= ilim_ma;
      end
    end
  end

  // control register; the strap forces standalone mode once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= CTRL_RESET;
    else if (strap_now && auto2)
    begin
      ctrl[CTRL_MODE_LO +: 2] <= MODE_AUTO;
      ctrl[CTRL_DET_EN]       <= 1'b1;
      ctrl[CTRL_CLS_EN]       <= 1'b1;
    end
    else if (wr && paddr == CTRL_ADDR)
      ctrl <= pwdata[6:0];
  end

  // ----------------------------------------------------------------
  // detection and classification sequence
  // ----------------------------------------------------------------
  assign start_det = det_ok && !port_power_on &&
                     (mode == MODE_SEMI || mode == MODE_AUTO ||
                      (cmd_wr && pwdata[CMD_DET]));
  assign start_cls = cls_ok && !port_power_on && mode == MODE_MANUAL &&
                     cmd_wr && pwdata[CMD_CLS];

  sig_encoder u_enc (
    .res_hohm   (meas_q.res_hohm),
    .cap_high   (meas_q.cap_high),
    .cap_legacy (meas_q.cap_legacy),
    .legacy_en  (ctrl[CTRL_LEG_EN]),
    .cls        (cls_q),
    .code       (enc_code),
    .icut_ma    (enc_icut),
    .ilim_ma    (enc_ilim)
  );

  // each measuring step: force, settle on the timer, sample, wait for done; the mark step only forces until its timer ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= S_IDLE;
      timer      <= 32'd0;
      armed      <= 1'b0;
      afe_sample <= 1'b0;
      auto_pwr   <= 1'b0;
      cur_good   <= 1'b0;
      det_code   <= DET_UNKNOWN;
      cls_q      <= 3'd0;
      second_ran <= 1'b0;
    end
    else
    begin
      afe_sample <= 1'b0;
      auto_pwr   <= 1'b0;
      if (timer != 32'd0)
        timer <= timer - 32'd1;
      if (state != S_IDLE && state != S_HOLD && state != S_MARK &&
          timer == 32'd0 && !armed)
      begin
        afe_sample <= 1'b1;
        armed      <= 1'b1;
      end
      unique case (state)
        S_IDLE:
          if (start_det)
          begin
            state <= S_DI1;
            timer <= STEP_CYC;
          end
          else if (start_cls)
          begin
            state      <= S_CLS1;
            timer      <= CLASS_CYCLES;
            second_ran <= 1'b0;
          end
        S_DI1:
          if (meas_ev && armed)
          begin
            armed <= 1'b0;
            if (meas_q.volt_mv < SHORT_MV)
            begin
              det_code <= DET_SHORT;
              state    <= S_IDLE;
            end
            else if (meas_q.volt_mv > RANGE_MV)
            begin
              det_code <= DET_VOLT_OUT;
              state    <= S_IDLE;
            end
            else
            begin
              state <= S_DI2;
              timer <= STEP_CYC;
            end
          end
        S_DI2:
          if (meas_ev && armed)
          begin
            armed    <= 1'b0;
            cur_good <= (enc_code == DET_GOOD);
            if (enc_code == DET_GOOD)
            begin
              state <= S_DV1;
              timer <= STEP_CYC;
            end
            else
            begin
              det_code <= enc_code;
              state    <= S_IDLE;
            end
          end
        S_DV1:
          if (meas_ev && armed)
          begin
            armed <= 1'b0;
            state <= S_DV2;
            timer <= STEP_CYC;
          end
        S_DV2:
          if (meas_ev && armed)
          begin
            armed    <= 1'b0;
            det_code <= cur_good ? enc_code : DET_UNKNOWN;
            if (enc_code != DET_GOOD)
              state <= S_IDLE;
            else if (cls_ok && mode != MODE_MANUAL)
            begin
              state      <= S_CLS1;
              timer      <= CLASS_CYCLES;
              second_ran <= 1'b0;
            end
            else if (mode == MODE_MANUAL)
              state <= S_IDLE;
            else
            begin
              auto_pwr <= (mode == MODE_AUTO);
              state    <= S_HOLD;
              timer    <= backoff;
            end
          end
        S_CLS1:
          if (meas_ev && armed)
          begin
            armed <= 1'b0;
            cls_q <= meas_q.cls;
            if (ctrl[CTRL_PP_EN] && meas_q.cls == CLS_4)
            begin
              state <= S_MARK;
              timer <= MARK_CYC;
            end
            else if (mode == MODE_MANUAL)
              state <= S_IDLE;
            else
            begin
              auto_pwr <= (mode == MODE_AUTO);
              state    <= S_HOLD;
              timer    <= backoff;
            end
          end
        S_MARK:
          if (timer == 32'd0)
          begin
            state      <= S_CLS2;
            timer      <= CLASS_CYCLES;
            second_ran <= 1'b1;
          end
        S_CLS2:
          if (meas_ev && armed)
          begin
            armed <= 1'b0;
            cls_q <= meas_q.cls;
            if (mode == MODE_MANUAL)
              state <= S_IDLE;
            else if (mode == MODE_AUTO && meas_q.cls != CLS_4)
              state <= S_IDLE;
            else
            begin
              auto_pwr <= (mode == MODE_AUTO);
              state    <= S_HOLD;
              timer    <= backoff;
            end
          end
        S_HOLD:
          if (timer == 32'd0)
            state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // front end force follows the state one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      afe_force <= F_OFF;
    else
      unique case (state)
        S_DI1:   afe_force <= F_CUR1;
        S_DI2:   afe_force <= F_CUR2;
        S_DV1:   afe_force <= F_VOLT1;
        S_DV2:   afe_force <= F_VOLT2;
        S_CLS1:  afe_force <= F_CLASS;
        S_CLS2:  afe_force <= F_CLASS;
        S_MARK:  afe_force <= F_MARK;
        default: afe_force <= F_OFF;
      endcase
  end

  // ----------------------------------------------------------------
  // power request handling and thresholds
  // ----------------------------------------------------------------
  // fault flag: a new fault wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_power_on <= 1'b0;
      tstart_fault  <= 1'b0;
      icut_ma       <= ICUT_C3;
      ilim_ma       <= ILIM_LO;
    end
    else
    begin
      if (wr && paddr == STATUS_ADDR && pwdata[ST_TSTART])
        tstart_fault <= 1'b0;
      if (mode == MODE_SHUTDOWN || (cmd_wr && pwdata[CMD_PWR_OFF]))
      begin
        port_power_on <= 1'b0;
        ilim_ma       <= ILIM_LO;
      end
      else if (auto_pwr)
      begin
        port_power_on <= 1'b1;
        icut_ma       <= enc_icut;
        ilim_ma       <= enc_ilim;
      end
      else if (cmd_wr && pwdata[CMD_PWR_ON] && mode != MODE_AUTO)
      begin
        // manual mode forces power regardless of detection
        if (mode == MODE_SEMI && ctrl[CTRL_HP_EN] && det_code != DET_GOOD)
          tstart_fault <= 1'b1;
        else
          port_power_on <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  short_abort_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == S_DI1 && meas_ev && armed && meas_q.volt_mv < SHORT_MV)
    |=> det_code == DET_SHORT && state == S_IDLE)
    else $error("short at first step not reported");

  range_out_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == S_DI1 && meas_ev && armed && meas_q.volt_mv > RANGE_MV)
    |=> det_code == DET_VOLT_OUT)
    else $error("out of range voltage not reported");

  volt_order_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == S_DV1 && $past(state) != S_DV1) |-> $past(state) == S_DI2)
    else $error("forced voltage without forced current");

  good_both_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (det_code == DET_GOOD && $past(det_code) != DET_GOOD)
    |-> $past(state) == S_DV2 && $past(cur_good))
    else $error("detect good without both measurements");

  shutdown_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == S_IDLE && !det_ok && !cls_ok) |=> state == S_IDLE)
    else $error("sequence started while disabled");

  class_force_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == S_CLS1 && $past(state) == S_CLS1) |-> afe_force == F_CLASS)
    else $error("class voltage not forced");

  pingpong_skip_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == S_CLS1 && meas_ev && armed &&
     (meas_q.cls != CLS_4 || !ctrl[CTRL_PP_EN])) |=> state != S_MARK)
    else $error("second class cycle without class 4");

  second_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == S_CLS2 && $past(state) != S_CLS2)
    |-> second_ran && !$past(second_ran) && $past(state) == S_MARK)
    else $error("second class cycle not recorded");

  hp_refuse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cmd_wr && pwdata[CMD_PWR_ON] && mode == MODE_SEMI &&
     ctrl[CTRL_HP_EN] && det_code != DET_GOOD && !pwdata[CMD_PWR_OFF])
    |=> tstart_fault && $stable(port_power_on))
    else $error("power on without detect good");

endmodule : port_sequencer

// >>> bench/afe_model.sv
// analog front end model answering sample requests
`timescale 1ns/1ps
module afe_model
  import psq_pkg::*;
(
  input  wire logic   pclk,
  input  wire force_e afe_force,
  input  wire logic   afe_sample,
  output logic        afe_done,
  output meas_s       afe_meas
);
  meas_s tbl [8];
  int    lag = 3;
  initial afe_done = 1'b0;
  initial afe_meas = '1;
  // data after lag cycles, done one cycle later; data inverted once done falls, never stale
  always @(posedge pclk)
    if (afe_sample)
    begin
      repeat (lag) @(posedge pclk);
      afe_meas <= tbl[afe_force];
      @(posedge pclk);
      afe_done <= 1'b1;
      repeat (4) @(posedge pclk);
      afe_done <= 1'b0;
      afe_meas <= ~tbl[afe_force];
    end
endmodule : afe_model

// >>> bench/test_port_sequencer.sv
// self-checking bench for the port sequencer
`timescale 1ns/1ps
module test_port_sequencer
  import psq_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, afe_sample, afe_done, pwr, e;
  logic        auto_pin = 0, mid_pin = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [9:0]  icut, ilim;
  force_e      afe_force;
  meas_s       afe_meas;
  int          n_errors = 0, cmp_count = 0;

  always #2.5 pclk = ~pclk;

  // small counts keep the run short
  port_sequencer #(.BACKOFF_CYCLES(50), .MID_BACKOFF_CYCLES(100),
    .CLASS_CYCLES(30)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .auto_strap_pin(auto_pin), .mid_strap_pin(mid_pin),
    .afe_force(afe_force), .afe_sample(afe_sample),
    .afe_done(afe_done), .afe_meas(afe_meas), .port_power_on(pwr),
    .icut_ma(icut), .ilim_ma(ilim));

  afe_model i_afe (.pclk(pclk), .afe_force(afe_force),
    .afe_sample(afe_sample), .afe_done(afe_done), .afe_meas(afe_meas));

  task automatic end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // apb transfer; request held until pready seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 20)
    begin
      n_errors++;
      end_sim();
    end
  endtask : apb

  // poll status until the masked field matches, bounded
  task automatic wait_st(input logic [31:0] m, input logic [31:0] x);
    for (int k = 0; k < 6000; k++)
    begin
      apb(1'b0, STATUS_ADDR, 32'h0);
      if ((r & m) === x)
        break;
    end
    chk(r & m, x);
  endtask : wait_st

  // manual detect command, then result and a return to idle
  task automatic t_det(input logic [15:0] v, input logic [15:0] r2,
                       input logic [15:0] r4, input det_e x);
    i_afe.tbl[F_CUR1] = '{v, 16'h00fa, 1'b0, 1'b0, 3'h0};
    i_afe.tbl[F_CUR2] = '{16'h07d0, r2, 1'b0, 1'b0, 3'h0};
    i_afe.tbl[F_VOLT2] = '{16'h07d0, r4, 1'b0, 1'b0, 3'h0};
    apb(1'b1, CMD_ADDR, 32'h1);
    wait_st(32'h7, {29'h0, x});
    repeat (100) @(posedge pclk);
    chk({29'h0, afe_force}, {29'h0, F_OFF});
    $display("detect test done");
  endtask : t_det

  task automatic t_reset;
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(r, {ILIM_LO, ICUT_C3, 12'h000});
    chk({12'h0, ilim, icut}, {12'h0, ILIM_LO, ICUT_C3});
    apb(1'b0, 12'hffc, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("reset test done");
  endtask : t_reset

  // two-event class on command in manual mode
  task automatic t_class;
    i_afe.tbl[F_CLASS] = '{16'h4650, 16'h0, 1'b0, 1'b0, CLS_4};
    apb(1'b1, CTRL_ADDR, 32'h2d);
    apb(1'b1, CMD_ADDR, 32'h2);
    wait_st(32'h1f0, 32'h140);
    $display("class test done");
  endtask : t_class

  // power-on refused in semi-auto on a bad result, forced in manual
  task automatic t_power;
    apb(1'b1, CTRL_ADDR, 32'h42);
    apb(1'b1, CMD_ADDR, 32'h4);
    wait_st(32'h600, 32'h400);
    apb(1'b1, CTRL_ADDR, 32'h41);
    apb(1'b1, CMD_ADDR, 32'h4);
    wait_st(32'h200, 32'h200);
    chk({31'h0, pwr}, 32'h1);
    $display("power test done");
  endtask : t_power

  // shutdown drops power and ignores a detect command
  task automatic t_shut;
    apb(1'b1, CTRL_ADDR, 32'h04);
    apb(1'b1, CMD_ADDR, 32'h1);
    repeat (50) @(posedge pclk);
    chk({29'h0, afe_force}, {29'h0, F_OFF});
    chk({31'h0, pwr}, 32'h0);
    $display("shutdown test done");
  endtask : t_shut

  // reset again with straps high: detect, classify, power on unaided
  task automatic t_auto;
    meas_s g;
    g = '{16'h07d0, 16'h00fa, 1'b0, 1'b0, 3'h0};
    i_afe.tbl[F_CUR1] = g;
    i_afe.tbl[F_CUR2] = g;
    i_afe.tbl[F_VOLT2] = g;
    presetn  <= 1'b0;
    auto_pin <= 1'b1;
    mid_pin  <= 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(r, 32'h0000_000f);
    wait_st(32'h277, 32'h244);
    chk({12'h0, ilim, icut}, {12'h0, ILIM_HI, ICUT_C4});
    $display("standalone test done");
  endtask : t_auto

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    t_reset();
    apb(1'b1, CTRL_ADDR, 32'h05);
    t_det(16'h07d0, 16'h00fa, 16'h00fa, DET_GOOD);
    t_det(16'h01f4, 16'h00fa, 16'h00fa, DET_SHORT);
    i_afe.lag = 40;
    t_det(16'h07d0, 16'h00fa, 16'h0064, DET_RSIG_LOW);
    t_det(16'h2ee0, 16'h00fa, 16'h00fa, DET_VOLT_OUT);
    t_class();
    t_power();
    t_shut();
    t_auto();
    end_sim();
  end
endmodule : test_port_sequencer
